/* File: pkg/aux_io_pkg.sv */
/*
  Shared constants and types for the auxiliary digital pin logic.
  Assumes a single controller clock domain and a plain register port.
*/
package aux_io_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STAT = 4'h1;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 4'h2;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'h3;
  localparam logic [ADDR_W-1:0] REG_EDGE_CNT = 4'h4;

  // Control field positions
  localparam int CTRL_DIR_BIT = 0;
  localparam int CTRL_INV_BIT = 1;
  localparam int CTRL_IN_LSB = 4;
  localparam int CTRL_OUT_LSB = 8;
  localparam int SEL_W = 3;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Interrupt bits
  localparam int IRQ_W = 3;
  localparam int IRQ_EDGE = 0;
  localparam int IRQ_ACTION = 1;
  localparam int IRQ_IGNORED = 2;

  localparam int CNT_W = 16;

  // ****************************************
  // Modes
  // ****************************************
  typedef enum logic [2:0] {
    IN_NOTHING = 3'b000,
    IN_HALT = 3'b001,
    IN_POWER_OFF = 3'b010,
    IN_REL_MOVE = 3'b011,
    IN_HOME = 3'b100,
    IN_ALARM = 3'b101
  } in_action_t;

  typedef enum logic [2:0] {
    OUT_OFF = 3'b000,
    OUT_ON = 3'b001,
    OUT_MOVING = 3'b010,
    OUT_ALARM = 3'b011,
    OUT_POWERED = 3'b100,
    OUT_PRESENT = 3'b101
  } out_cond_t;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic moving;
    logic alarm;
    logic powered;
    logic present;
  } ctl_status_t;

  typedef struct packed {
    logic halt;
    logic power_off_command;
    logic rel_move;
    logic home;
    logic alarm;
  } ctl_cmd_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage

/* File: hdl/aux_edge_detect.sv */
/*
  Edge detector for the auxiliary pin with selectable active edge.
  Assumes the pin input is already synchronous to clk.
*/
`timescale 1ns/10ps
module aux_edge_detect (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin_in,
  input wire logic invert,
  output logic active_edge,
  output logic level
);

  logic prev_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= pin_in;
    end
  end

  // Only the edge direction selected by invert is reported
  always_comb begin
    if (invert) begin
      active_edge = prev_q & ~pin_in;
    end else begin
      active_edge = ~prev_q & pin_in;
    end
  end

  assign level = prev_q;

endmodule

/* File: hdl/aux_io_pin_action_logic.sv */
/*
  Auxiliary digital pin: input edges trigger controller actions, or the
  pin shows a selected controller condition as an output.
  Assumes synchronous pin input, a one-clock register port with read
  data one cycle later, and a controller that obeys one-cycle commands.
*/
`timescale 1ns/10ps

module aux_io_pin_action_logic
  import aux_io_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire ctl_status_t status,
  output ctl_cmd_t cmd,
  input wire logic aux_digital_pin_i,
  output logic aux_digital_pin_o,
  output logic aux_digital_pin_oe,
  output logic irq
);

  // ****************************************
  // Configuration registers
  // ****************************************
  reg_req_t req;
  logic dir_out_q;
  logic invert_q;
  logic [SEL_W-1:0] in_sel_q;
  logic [SEL_W-1:0] out_sel_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_stat_d;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [CNT_W-1:0] edge_cnt_q;
  logic [IRQ_W-1:0] events;
  logic edge_seen;
  logic pin_level;
  logic fire;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_out_q <= CTRL_RESET[CTRL_DIR_BIT];
      invert_q <= CTRL_RESET[CTRL_INV_BIT];
      in_sel_q <= CTRL_RESET[CTRL_IN_LSB +: SEL_W];
      out_sel_q <= CTRL_RESET[CTRL_OUT_LSB +: SEL_W];
    end else if (req.wr && req.addr == REG_CTRL) begin
      dir_out_q <= req.wdata[CTRL_DIR_BIT];
      invert_q <= req.wdata[CTRL_INV_BIT];
      in_sel_q <= req.wdata[CTRL_IN_LSB +: SEL_W];
      out_sel_q <= req.wdata[CTRL_OUT_LSB +: SEL_W];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_q <= '0;
    end else if (req.wr && req.addr == REG_IRQ_MASK) begin
      irq_mask_q <= req.wdata[IRQ_W-1:0];
    end
  end

  // ****************************************
  // Input side
  // ****************************************
  aux_edge_detect aux_edge_detect_i (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in(aux_digital_pin_i),
    .invert(invert_q),
    .active_edge(edge_seen),
    .level(pin_level)
  );

  // Own driven level is reflected back; gating keeps it from self-triggering
  assign fire = edge_seen & ~dir_out_q;

  // Commands are registered so they reach the controller glitch free
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd <= '0;
    end else begin
      cmd <= '0;
      if (fire) begin
        case (in_action_t'(in_sel_q))
          IN_NOTHING: cmd <= '0;
          IN_HALT: cmd.halt <= 1'b1;
          IN_POWER_OFF: cmd.power_off_command <= 1'b1;
          IN_REL_MOVE: cmd.rel_move <= 1'b1;
          IN_HOME: cmd.home <= 1'b1;
          IN_ALARM: cmd.alarm <= 1'b1;
          default: cmd <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_cnt_q <= '0;
    end else if (req.wr && req.addr == REG_EDGE_CNT) begin
      edge_cnt_q <= '0;
    end else if (fire) begin
      edge_cnt_q <= edge_cnt_q + 1'b1;
    end
  end

  // ****************************************
  // Output side
  // ****************************************
  logic cond_active;

  always_comb begin
    case (out_cond_t'(out_sel_q))
      OUT_OFF: cond_active = 1'b0;
      OUT_ON: cond_active = 1'b1;
      OUT_MOVING: cond_active = status.moving;
      OUT_ALARM: cond_active = status.alarm;
      OUT_POWERED: cond_active = status.powered;
      OUT_PRESENT: cond_active = status.present;
      default: cond_active = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aux_digital_pin_o <= 1'b0;
    end else begin
      aux_digital_pin_o <= cond_active ^ invert_q;
    end
  end

  assign aux_digital_pin_oe = dir_out_q;

  // ****************************************
  // Interrupts
  // ****************************************
  always_comb begin
    events = '0;
    events[IRQ_EDGE] = edge_seen;
    events[IRQ_ACTION] = fire && in_sel_q != SEL_W'(IN_NOTHING);
    events[IRQ_IGNORED] = edge_seen & dir_out_q;
  end

  // New events win over a write-one clear in the same cycle
  always_comb begin
    irq_stat_d = irq_stat_q;
    if (req.wr && req.addr == REG_IRQ_STAT) begin
      irq_stat_d = irq_stat_q & ~req.wdata[IRQ_W-1:0];
    end
    irq_stat_d = irq_stat_d | events;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= irq_stat_d;
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // ****************************************
  // Read port
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (req.rd) begin
      case (req.addr)
        REG_CTRL: begin
          reg_rdata <= '0;
          reg_rdata[CTRL_DIR_BIT] <= dir_out_q;
          reg_rdata[CTRL_INV_BIT] <= invert_q;
          reg_rdata[CTRL_IN_LSB +: SEL_W] <= in_sel_q;
          reg_rdata[CTRL_OUT_LSB +: SEL_W] <= out_sel_q;
        end
        REG_STAT: reg_rdata <= {30'h0, aux_digital_pin_o, pin_level};
        REG_IRQ_STAT: reg_rdata <= 32'(irq_stat_q);
        REG_IRQ_MASK: reg_rdata <= 32'(irq_mask_q);
        REG_EDGE_CNT: reg_rdata <= 32'(edge_cnt_q);
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_input_gated: assert property (@(posedge clk) disable iff (!rst_n)
    dir_out_q |-> ##1 cmd == '0)
    else $error("command issued in output mode");

  a_cmd_needs_in: assert property (@(posedge clk) disable iff (!rst_n)
    cmd != '0 |-> !$past(dir_out_q))
    else $error("command follows an output mode cycle");

  a_ignored_flag: assert property (@(posedge clk) disable iff (!rst_n)
    dir_out_q && edge_seen |=> irq_stat_q[IRQ_IGNORED])
    else $error("ignored edge not flagged");

  a_halt_cmd: assert property (@(posedge clk) disable iff (!rst_n)
    fire && in_sel_q == SEL_W'(IN_HALT) |=> cmd.halt)
    else $error("halt not issued");

  a_poweroff_cmd: assert property (@(posedge clk) disable iff (!rst_n)
    fire && in_sel_q == SEL_W'(IN_POWER_OFF) |=> cmd.power_off_command)
    else $error("power off not issued");

  a_move_cmd: assert property (@(posedge clk) disable iff (!rst_n)
    fire && in_sel_q == SEL_W'(IN_REL_MOVE) |=> cmd.rel_move)
    else $error("relative move not issued");

  a_home_cmd: assert property (@(posedge clk) disable iff (!rst_n)
    fire && in_sel_q == SEL_W'(IN_HOME) |=> cmd.home)
    else $error("home not issued");

  a_alarm_cmd: assert property (@(posedge clk) disable iff (!rst_n)
    fire && in_sel_q == SEL_W'(IN_ALARM) |=> cmd.alarm)
    else $error("alarm not issued");

  // Reverse direction: a command bit only from its own selection
  a_halt_only: assert property (@(posedge clk) disable iff (!rst_n)
    cmd.halt |-> $past(in_sel_q) == SEL_W'(IN_HALT))
    else $error("halt from another selection");

  a_poff_only: assert property (@(posedge clk) disable iff (!rst_n)
    cmd.power_off_command |-> $past(in_sel_q) == SEL_W'(IN_POWER_OFF))
    else $error("power off from another selection");

  a_move_only: assert property (@(posedge clk) disable iff (!rst_n)
    cmd.rel_move |-> $past(in_sel_q) == SEL_W'(IN_REL_MOVE))
    else $error("relative move from another selection");

  a_home_only: assert property (@(posedge clk) disable iff (!rst_n)
    cmd.home |-> $past(in_sel_q) == SEL_W'(IN_HOME))
    else $error("home from another selection");

  a_alarm_only: assert property (@(posedge clk) disable iff (!rst_n)
    cmd.alarm |-> $past(in_sel_q) == SEL_W'(IN_ALARM))
    else $error("alarm from another selection");

  a_nothing_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    in_sel_q == SEL_W'(IN_NOTHING) |=> cmd == '0)
    else $error("do-nothing produced a command");

  a_edge_flag: assert property (@(posedge clk) disable iff (!rst_n)
    edge_seen |=> irq_stat_q[IRQ_EDGE])
    else $error("active edge not flagged");

  a_action_flag: assert property (@(posedge clk) disable iff (!rst_n)
    fire && in_sel_q != SEL_W'(IN_NOTHING) |=> irq_stat_q[IRQ_ACTION])
    else $error("issued action not flagged");

  a_rise_edge: assert property (@(posedge clk) disable iff (!rst_n)
    !invert_q && $fell(aux_digital_pin_i) |-> !edge_seen)
    else $error("falling edge taken while not swapped");

  // First cycle after reset skipped: the history flop starts low
  a_rise_taken: assert property (@(posedge clk) disable iff (!rst_n)
    !invert_q && $rose(aux_digital_pin_i) && $past(rst_n) |-> edge_seen)
    else $error("rising edge missed while not swapped");

  a_fall_edge: assert property (@(posedge clk) disable iff (!rst_n)
    invert_q && $rose(aux_digital_pin_i) |-> !edge_seen)
    else $error("rising edge taken while swapped");

  a_fall_taken: assert property (@(posedge clk) disable iff (!rst_n)
    invert_q && $fell(aux_digital_pin_i) && $past(rst_n) |-> edge_seen)
    else $error("falling edge missed while swapped");

  a_dir_write: assert property (@(posedge clk) disable iff (!rst_n)
    reg_wr && reg_addr == REG_CTRL
    |=> aux_digital_pin_oe == $past(reg_wdata[CTRL_DIR_BIT]))
    else $error("pin direction not taken from control write");

  a_out_off: assert property (@(posedge clk) disable iff (!rst_n)
    out_sel_q == SEL_W'(OUT_OFF) && $stable(out_sel_q) && $stable(invert_q)
    |-> aux_digital_pin_o == invert_q)
    else $error("constant off not inactive");

  a_out_on: assert property (@(posedge clk) disable iff (!rst_n)
    out_sel_q == SEL_W'(OUT_ON) && $stable(out_sel_q) && $stable(invert_q)
    |-> aux_digital_pin_o == !invert_q)
    else $error("constant on not active");

  a_out_moving: assert property (@(posedge clk) disable iff (!rst_n)
    out_sel_q == SEL_W'(OUT_MOVING) && !invert_q
    |=> aux_digital_pin_o == $past(status.moving))
    else $error("moving output wrong");

  a_out_alarm: assert property (@(posedge clk) disable iff (!rst_n)
    out_sel_q == SEL_W'(OUT_ALARM) && !invert_q
    |=> aux_digital_pin_o == $past(status.alarm))
    else $error("alarm output wrong");

  a_out_powered: assert property (@(posedge clk) disable iff (!rst_n)
    out_sel_q == SEL_W'(OUT_POWERED) && !invert_q
    |=> aux_digital_pin_o == $past(status.powered))
    else $error("powered output wrong");

  a_out_present: assert property (@(posedge clk) disable iff (!rst_n)
    out_sel_q == SEL_W'(OUT_PRESENT) && !invert_q
    |=> aux_digital_pin_o == $past(status.present))
    else $error("present output wrong");

  // Swapped polarity: the same conditions, active level low
  a_move_swap: assert property (@(posedge clk) disable iff (!rst_n)
    out_sel_q == SEL_W'(OUT_MOVING) && invert_q
    |=> aux_digital_pin_o == !$past(status.moving))
    else $error("swapped moving output wrong");

  a_alarm_swap: assert property (@(posedge clk) disable iff (!rst_n)
    out_sel_q == SEL_W'(OUT_ALARM) && invert_q
    |=> aux_digital_pin_o == !$past(status.alarm))
    else $error("swapped alarm output wrong");

  a_out_swapped: assert property (@(posedge clk) disable iff (!rst_n)
    out_sel_q == SEL_W'(OUT_POWERED) && invert_q
    |=> aux_digital_pin_o == !$past(status.powered))
    else $error("swapped powered output wrong");

  a_present_swap: assert property (@(posedge clk) disable iff (!rst_n)
    out_sel_q == SEL_W'(OUT_PRESENT) && invert_q
    |=> aux_digital_pin_o == !$past(status.present))
    else $error("swapped present output wrong");

endmodule

/* File: bench/aux_pin_partner.sv */
/*
  Far-side equipment on the auxiliary pin: drives it while the block
  listens, senses it while the block drives.
  Assumes the bench changes drv_level just after a rising clock edge.
*/
`timescale 1ns/10ps
module aux_pin_partner (
  input wire logic drv_level,
  input wire logic pin_o,
  input wire logic pin_oe,
  output logic pin_i,
  output logic sensed
);
  // Equipment backs off while the block drives, so no contention
  assign pin_i = pin_oe ? pin_o : drv_level;
  assign sensed = pin_i;
endmodule

/* File: bench/aux_io_pin_action_logic_tb.sv */
/*
  Self-checking bench for the auxiliary pin block.
  Assumes one 50 MHz clock and the far-side model aux_pin_partner.
*/
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
  $display("BAD t=%0t got %0h exp %0h", $time, a, b); end end
module aux_io_pin_action_logic_tb import aux_io_pkg::*;;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, d;
  ctl_status_t status = '0;
  ctl_status_t sv;
  ctl_cmd_t cmd, seen;
  logic pin_i, pin_o, pin_oe, irq, sensed, inv;
  logic drv = 1'b0;
  int num_errors = 0;
  int checked = 0;
  int pulses;

  always #10 clk = ~clk;

  aux_io_pin_action_logic aux_io_pin_action_logic_i (.clk(clk),
    .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .status(status), .cmd(cmd), .aux_digital_pin_i(pin_i),
    .aux_digital_pin_o(pin_o), .aux_digital_pin_oe(pin_oe), .irq(irq));
  aux_pin_partner aux_pin_partner_i (.drv_level(drv), .pin_o(pin_o),
    .pin_oe(pin_oe), .pin_i(pin_i), .sensed(sensed));

  // ****************************************
  // Bus tasks and expectations
  // ****************************************
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask

  task automatic pin(input logic v);
    @(posedge clk);
    drv <= v;
  endtask

  // Collects command pulses; a pulse lasts one cycle, so sample each one
  task automatic watch(input int n);
    seen = '0;
    pulses = 0;
    repeat (n) begin
      @(negedge clk);
      seen = seen | cmd;
      pulses += int'(cmd != '0);
    end
  endtask

  function automatic ctl_cmd_t exp_cmd(input int a);
    ctl_cmd_t c = '0;
    case (a)
      1: c.halt = 1'b1;
      2: c.power_off_command = 1'b1;
      3: c.rel_move = 1'b1;
      4: c.home = 1'b1;
      5: c.alarm = 1'b1;
      default: c = '0;
    endcase
    return c;
  endfunction

  function automatic logic exp_out(int c, ctl_status_t s, logic i);
    logic v;
    case (c)
      1: v = 1'b1;
      2: v = s.moving;
      3: v = s.alarm;
      4: v = s.powered;
      5: v = s.present;
      default: v = 1'b0;
    endcase
    return v ^ i;
  endfunction

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    #200us;
    num_errors++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(6363));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 6; a++) begin
      for (int i = 0; i < 2; i++) begin
        pin(i[0]);
        wr(REG_CTRL, 32'(a << CTRL_IN_LSB) | 32'(i << CTRL_INV_BIT));
        watch(3);
        `CHK(pin_oe, 1'b0)
        pin(~i[0]);
        watch(4);
        `CHK(seen, exp_cmd(a))
        `CHK(pulses, int'(a != 0))
        pin(i[0]);
        watch(4);
        `CHK(seen, ctl_cmd_t'(0))
      end
    end
    $display("input actions done");
    for (int c = 0; c < 6; c++) begin
      inv = 1'($urandom_range(1, 0));
      wr(REG_CTRL, 32'h1 | 32'(inv) << CTRL_INV_BIT
        | 32'(c << CTRL_OUT_LSB) | 32'(IN_HALT) << CTRL_IN_LSB);
      repeat (4) begin
        sv = ctl_status_t'($urandom_range(15, 0));
        @(posedge clk);
        status <= sv;
        drv <= 1'($urandom_range(1, 0));
        watch(3);
        `CHK(seen, ctl_cmd_t'(0))
        `CHK(pin_oe, 1'b1)
        `CHK(sensed, exp_out(c, sv, inv))
      end
    end
    $display("output conditions done");
    pin(1'b0);
    wr(REG_CTRL, 32'(IN_HALT) << CTRL_IN_LSB);
    watch(2);
    wr(REG_IRQ_STAT, 32'h7);
    wr(REG_IRQ_MASK, 32'h2);
    pin(1'b1);
    watch(4);
    `CHK(seen, exp_cmd(1))
    rd(REG_IRQ_STAT);
    `CHK(d, 32'h3)
    `CHK(irq, 1'b1)
    wr(REG_IRQ_MASK, 32'h0);
    watch(2);
    `CHK(irq, 1'b0)
    wr(REG_IRQ_MASK, 32'h2);
    watch(2);
    `CHK(irq, 1'b1)
    wr(REG_IRQ_STAT, 32'h3);
    watch(2);
    `CHK(irq, 1'b0)
    rd(REG_IRQ_STAT);
    `CHK(d, 32'h0)
    rd(4'hf);
    `CHK(d, 32'h0)
    rd(REG_CTRL);
    `CHK(d, 32'(IN_HALT) << CTRL_IN_LSB)
    rd(REG_IRQ_MASK);
    `CHK(d, 32'h2)
    wr(REG_EDGE_CNT, 32'h0);
    pin(1'b0);
    watch(2);
    pin(1'b1);
    watch(2);
    rd(REG_EDGE_CNT);
    `CHK(d, 32'h1)
    rd(REG_STAT);
    `CHK(d, 32'h1)
    $display("registers and interrupt done");
    tally_and_finish();
  end
endmodule
